/* pkg/host_port_pkg.sv */
// Constants and carrier types shared by the host microcomputer port.
package host_port_pkg;

    // Register locations on the host port.
    localparam logic [7:0] TOP_CONTROL_STATUS_OFS = 8'h00;
    localparam logic [7:0] MONITOR_OUTPUT_SELECT_OFS = 8'h01;
    localparam logic [7:0] LINE_SIDE_PORT_CONFIG_OFS = 8'h06;
    localparam logic [7:0] SYNTH_CONFIG_OFS = 8'h22;
    localparam logic [7:0] IRQ_FLAGS_OFS = 8'h40;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h41;

    // Field positions.
    localparam int SLEEP_BIT = 0;
    localparam int STATUS_LSB = 4;
    localparam int STATUS_WIDTH = 4;
    localparam int SYNTH_RATE_LSB = 0;
    localparam int HOST_CLK_RATE_LSB = 0;
    localparam int RATE_WIDTH = 2;

    // Reset values.
    localparam logic [7:0] TOP_CONTROL_STATUS_RST = 8'h01;
    localparam logic [7:0] MONITOR_OUTPUT_SELECT_RST = 8'h00;
    localparam logic [7:0] LINE_SIDE_PORT_CONFIG_RST = 8'h00;
    localparam logic [7:0] SYNTH_CONFIG_RST = 8'h00;
    localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Timing: stages of every pin synchroniser.
    localparam int SYNC_STAGES = 2;

    // Host strobe and mode pins, grouped as they arrive.
    typedef struct packed {
        logic cs_n;
        logic host_style_select;
        logic bus_sharing_select;
        logic combined_fetch_pin;
        logic combined_store_pin;
        logic ale;
    } host_ctrl_t;

    // Host byte and location buses.
    typedef struct packed {
        logic [7:0] ad;
        logic [7:0] addr;
    } host_bus_t;

    localparam int CTRL_WIDTH = $bits(host_ctrl_t);
    localparam int BUS_WIDTH = $bits(host_bus_t);

endpackage : host_port_pkg

/* hw/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] rst_value,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    // The second stage holds a real pin sample only from the second edge after
    // reset; until then the idle pattern is shown, so the all-zero reset contents
    // never look like an active-low strobe.
    logic [1:0] primed_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            primed_q <= 2'b00;
        end else begin
            primed_q <= {primed_q[0], 1'b1};
        end
    end

    assign sync_out = primed_q[1] ? sync_q : rst_value;

endmodule : pin_sync

/* hw/host_port.sv */
// Host microcomputer port: strobe decoding, register file and open-drain outputs.
`timescale 1ns/1ps

// What this block does
// R1 - Select-line style: read drives byte bus
// R2 - Select-line style: write on strobe rise
// R3 - Strobe style: write on store strobe rise
// R4 - Store strobe never affects reads
// R5 - Byte bus eight bits, bit 7 MSB
// R6 - Sharing high: location and data multiplexed
// R7 - Sharing low: location from separate bus
// R8 - Location bus eight bits, bit 7 MSB
// R9 - Ready output pulled low when transfer completes
// R10 - Interrupt pulled low on unmasked set flag
// R11 - Interrupt released when none unmasked set
// R12 - Reset sets sleep bit
// R13 - Reset clears both two-bit rate fields
// R14 - Internal RAM undefined after reset
// R15 - Reset leaves test access port alone
// R16 - Style select picks handshake convention
// R17 - Location latched on latch strobe fall
// R18 - Transfers only while chip select low
// R19 - Strobe style: fetch strobe drives byte bus
// R20 - Byte bus driven only during selected read
// R21 - Open-drain outputs as pull-low enables
module host_port (
    input wire logic clk,
    input wire logic rst,
    input wire host_port_pkg::host_ctrl_t ctrl_pins,
    input wire host_port_pkg::host_bus_t bus_pins,
    output logic [7:0] ad_out,
    output logic ad_oe,
    output logic ready_out,
    output logic ready_oe,
    output logic irq_out,
    output logic irq_oe,
    input wire logic [7:0] irq_events,
    input wire logic [3:0] core_status,
    output logic sleep,
    output logic [1:0] synth_rate,
    output logic [1:0] host_clk_rate,
    output logic [7:0] monitor_select,
    output logic [7:0] line_port_config
);

    // ------------------------------------------------------------------
    // Pin synchronisation.
    // ------------------------------------------------------------------

    localparam host_port_pkg::host_ctrl_t CTRL_IDLE = '{
        cs_n: 1'b1,
        host_style_select: 1'b0,
        bus_sharing_select: 1'b0,
        combined_fetch_pin: 1'b1,
        combined_store_pin: 1'b1,
        ale: 1'b0
    };

    host_port_pkg::host_ctrl_t ctrl_s;
    host_port_pkg::host_bus_t bus_s;
    logic [host_port_pkg::CTRL_WIDTH-1:0] ctrl_s_raw;
    logic [host_port_pkg::BUS_WIDTH-1:0] bus_s_raw;

    pin_sync #(
        .WIDTH(host_port_pkg::CTRL_WIDTH)
    ) u_ctrl_sync (
        .clk(clk),
        .rst(rst),
        .async_in(ctrl_pins),
        .rst_value(CTRL_IDLE),
        .sync_out(ctrl_s_raw)
    );

    pin_sync #(
        .WIDTH(host_port_pkg::BUS_WIDTH)
    ) u_bus_sync (
        .clk(clk),
        .rst(rst),
        .async_in(bus_pins),
        .rst_value('0),
        .sync_out(bus_s_raw)
    );

    assign ctrl_s = host_port_pkg::host_ctrl_t'(ctrl_s_raw);
    assign bus_s = host_port_pkg::host_bus_t'(bus_s_raw);

    // ------------------------------------------------------------------
    // Strobe decoding.
    // ------------------------------------------------------------------

    wire selected = !ctrl_s.cs_n; // R18
    wire style_select_line = ctrl_s.host_style_select; // R16
    wire fetch_low = !ctrl_s.combined_fetch_pin;
    wire store_low = !ctrl_s.combined_store_pin;

    // In select-line style the store pin is a level, high meaning read.
    wire sl_read = selected && style_select_line && fetch_low && ctrl_s.combined_store_pin; // R1
    wire sl_write = selected && style_select_line && fetch_low && store_low; // R2
    // In strobe style reads look at the fetch strobe only.
    wire st_read = selected && !style_select_line && fetch_low; // R19 R4
    wire st_write = selected && !style_select_line && store_low; // R3

    // Both strobe styles feed the same read and write paths below.
    wire read_active = sl_read || st_read;
    wire write_active = sl_write || st_write;

    logic write_active_q;
    logic ale_q;
    logic [7:0] wr_data_q;

    // A write completes when its strobe rises; the byte seen while the strobe
    // was low is used, since the bus may already be turning at the rising edge.
    // A chip select that rises together with the strobe also ends the write,
    // which suits hosts that drop both at once.
    wire write_commit = write_active_q && !write_active; // R2 R3

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_active_q <= 1'b0;
            ale_q <= 1'b0;
        end else begin
            write_active_q <= write_active;
            ale_q <= ctrl_s.ale;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_data_q <= 8'h00;
        end else if (write_active) begin
            wr_data_q <= bus_s.ad; // R5
        end
    end

    // ------------------------------------------------------------------
    // Location latch.
    // ------------------------------------------------------------------

    logic [7:0] loc_q;
    wire ale_fall = ale_q && !ctrl_s.ale;
    wire [7:0] loc_source = ctrl_s.bus_sharing_select ? bus_s.ad : bus_s.addr; // R6 R7 R8

    // The latch strobe needs no chip select, matching a shared address cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loc_q <= 8'h00;
        end else if (ale_fall) begin
            loc_q <= loc_source; // R17
        end
    end

    // ------------------------------------------------------------------
    // Register file.
    // ------------------------------------------------------------------

    logic [7:0] top_ctrl_q;
    logic [7:0] monitor_sel_q;
    logic [7:0] line_cfg_q;
    logic [7:0] synth_cfg_q;
    logic [7:0] irq_flags_q;
    logic [7:0] irq_mask_q;
    logic [7:0] irq_flags_d;

    wire hit_top = loc_q == host_port_pkg::TOP_CONTROL_STATUS_OFS;
    wire hit_mon = loc_q == host_port_pkg::MONITOR_OUTPUT_SELECT_OFS;
    wire hit_line = loc_q == host_port_pkg::LINE_SIDE_PORT_CONFIG_OFS;
    wire hit_synth = loc_q == host_port_pkg::SYNTH_CONFIG_OFS;
    wire hit_flags = loc_q == host_port_pkg::IRQ_FLAGS_OFS;
    wire hit_mask = loc_q == host_port_pkg::IRQ_MASK_OFS;

    wire wr_top = write_commit && hit_top;
    wire wr_mon = write_commit && hit_mon;
    wire wr_line = write_commit && hit_line;
    wire wr_synth = write_commit && hit_synth;
    wire wr_flags = write_commit && hit_flags;
    wire wr_mask = write_commit && hit_mask;

    // Upper nibble of the top register reports core status and is read-only.
    // The stored upper nibble stays zero; reads show core status there instead.
    wire [7:0] top_wr_value = {4'h0, wr_data_q[3:0]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            top_ctrl_q <= host_port_pkg::TOP_CONTROL_STATUS_RST; // R12
        end else if (wr_top) begin
            top_ctrl_q <= top_wr_value;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            monitor_sel_q <= host_port_pkg::MONITOR_OUTPUT_SELECT_RST; // R13
        end else if (wr_mon) begin
            monitor_sel_q <= wr_data_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_cfg_q <= host_port_pkg::LINE_SIDE_PORT_CONFIG_RST;
        end else if (wr_line) begin
            line_cfg_q <= wr_data_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            synth_cfg_q <= host_port_pkg::SYNTH_CONFIG_RST; // R13
        end else if (wr_synth) begin
            synth_cfg_q <= wr_data_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= host_port_pkg::IRQ_MASK_RST;
        end else if (wr_mask) begin
            irq_mask_q <= wr_data_q;
        end
    end

    // Writing a one clears a flag, but an event in the same cycle keeps it set,
    // so a flag raised while the host clears older ones is never lost.
    wire [7:0] irq_clear = wr_flags ? wr_data_q : 8'h00;
    wire [7:0] irq_kept = irq_flags_q & ~irq_clear;

    assign irq_flags_d = irq_kept | irq_events;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_flags_q <= host_port_pkg::IRQ_FLAGS_RST;
        end else begin
            irq_flags_q <= irq_flags_d;
        end
    end

    // ------------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------------

    wire [7:0] top_rd_value = {
        core_status,
        top_ctrl_q[host_port_pkg::STATUS_LSB-1:0]
    };

    // An unmapped location reads as a fixed byte, never as stale bus contents.
    wire [7:0] read_value =
        hit_top ? top_rd_value :
        hit_mon ? monitor_sel_q :
        hit_line ? line_cfg_q :
        hit_synth ? synth_cfg_q :
        hit_flags ? irq_flags_q :
        hit_mask ? irq_mask_q :
        host_port_pkg::UNMAPPED_READ;

    logic [7:0] ad_out_q;
    logic ad_oe_q;
    logic ready_oe_q;

    // The byte is captured for the whole read so the bus does not change
    // under the host if a flag or status bit moves mid-cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ad_out_q <= 8'h00;
        end else if (read_active && !ad_oe_q) begin
            ad_out_q <= read_value; // R1 R19
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ad_oe_q <= 1'b0;
        end else begin
            ad_oe_q <= read_active; // R20
        end
    end

    // Ready is pulled low once the data is on the bus or the write byte is held.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_oe_q <= 1'b0;
        end else begin
            ready_oe_q <= (read_active && ad_oe_q) || (write_active && write_active_q); // R9
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output.
    // ------------------------------------------------------------------

    logic irq_oe_q;
    wire irq_pending = |(irq_flags_q & ~irq_mask_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_oe_q <= 1'b0;
        end else begin
            irq_oe_q <= irq_pending; // R10 R11
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------

    // Open-drain pins only ever drive low; the enable carries the state.
    logic ready_out_q;
    logic irq_out_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_out_q <= 1'b0;
            irq_out_q <= 1'b0;
        end else begin
            ready_out_q <= 1'b0; // R21
            irq_out_q <= 1'b0; // R21
        end
    end

    assign ad_out = ad_out_q;
    assign ad_oe = ad_oe_q;
    assign ready_out = ready_out_q;
    assign ready_oe = ready_oe_q;
    assign irq_out = irq_out_q;
    assign irq_oe = irq_oe_q;

    // Configuration outputs come straight from the register flip-flops.
    assign sleep = top_ctrl_q[host_port_pkg::SLEEP_BIT];
    assign synth_rate = synth_cfg_q[host_port_pkg::SYNTH_RATE_LSB +: host_port_pkg::RATE_WIDTH];
    assign host_clk_rate =
        monitor_sel_q[host_port_pkg::HOST_CLK_RATE_LSB +: host_port_pkg::RATE_WIDTH];
    assign monitor_select = monitor_sel_q;
    assign line_port_config = line_cfg_q;

    // This port holds no RAM, so nothing here needs reloading after reset; the
    // core's own RAM is left as it is. R14
    // Only the registers above have reset values; the host must reload any core
    // memory that it relies on after a reset.
    // The test access port lives elsewhere and never sees this reset. R15

endmodule : host_port

/* testbench/host_port_chk.sv */
// Concurrent checks on the host port pins and register outputs.
`timescale 1ns/1ps
module host_port_chk (
    input wire logic clk,
    input wire logic rst,
    input wire host_port_pkg::host_ctrl_t ctrl_pins,
    input wire host_port_pkg::host_bus_t bus_pins,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic ready_out,
    input wire logic ready_oe,
    input wire logic irq_out,
    input wire logic irq_oe,
    input wire logic [7:0] irq_events,
    input wire logic [3:0] core_status,
    input wire logic sleep,
    input wire logic [1:0] synth_rate,
    input wire logic [1:0] host_clk_rate,
    input wire logic [7:0] monitor_select,
    input wire logic [7:0] line_port_config
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire sel = !ctrl_pins.cs_n;
    wire sty = ctrl_pins.host_style_select;
    wire lo_f = !ctrl_pins.combined_fetch_pin;
    wire dir = ctrl_pins.combined_store_pin;
    // Five samples leave room for the two synchroniser stages and the output flop.
    chk_read_sel: assert property ((sel && sty && lo_f && dir)[*5] |-> ad_oe)
        else $error("select read not driven");
    chk_read_strobe: assert property ((sel && !sty && lo_f)[*5] |-> ad_oe)
        else $error("strobe read not driven");
    chk_store_no_read: assert property ((sel && !sty && !lo_f)[*4] |=> !ad_oe)
        else $error("store strobe drove bus");
    chk_write_no_drive: assert property ((sel && sty && !dir)[*4] |=> !ad_oe)
        else $error("bus driven in write");
    chk_idle_release: assert property (ctrl_pins.cs_n[*4] |=> !ad_oe && !ready_oe)
        else $error("active while deselected");
    chk_drive_cause: assert property ($rose(ad_oe) |-> $past(sel, 2) && $past(lo_f, 2))
        else $error("bus driven without read");
    chk_ready_follow: assert property ($rose(ad_oe) |=> ready_oe)
        else $error("ready late on read");
    chk_pull_low: assert property (!ready_out && !irq_out)
        else $error("open drain drives high");
    chk_reset_state: assert property ($fell(rst) |-> sleep && {synth_rate, host_clk_rate} == 4'h0)
        else $error("reset state wrong");
    cover property ($rose(ad_oe));
    cover property ($rose(irq_oe));
    cover property ($fell(sleep));
endmodule : host_port_chk

bind host_port host_port_chk u_chk (.clk(clk), .rst(rst), .ctrl_pins(ctrl_pins),
    .bus_pins(bus_pins), .ad_out(ad_out), .ad_oe(ad_oe), .ready_out(ready_out),
    .ready_oe(ready_oe), .irq_out(irq_out), .irq_oe(irq_oe), .irq_events(irq_events),
    .core_status(core_status), .sleep(sleep), .synth_rate(synth_rate),
    .host_clk_rate(host_clk_rate), .monitor_select(monitor_select),
    .line_port_config(line_port_config));

/* testbench/host_bus_model.sv */
// Host processor model driving strobes, location and the shared byte bus.
`timescale 1ns/1ps
module host_bus_model (
    input wire logic clk,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic ready_out,
    input wire logic ready_oe,
    output host_port_pkg::host_ctrl_t ctrl,
    output host_port_pkg::host_bus_t bus
);
    logic [7:0] host_ad;
    logic host_en;
    logic [7:0] float_q;
    logic [7:0] ad_q;
    logic [7:0] addr_v;
    logic rdy_q;
    logic got_ready;
    // A released bus toggles every cycle so a stale byte is never read as valid.
    wire [7:0] ad_w = ad_oe ? ad_out : (host_en ? host_ad : float_q);
    wire rdy_line = ready_oe ? ready_out : 1'b1;
    assign bus = {ad_w, addr_v};
    initial begin
        ctrl = 6'h3e;
        host_ad = 8'h00;
        host_en = 1'b0;
        float_q = 8'h55;
        addr_v = 8'h00;
        got_ready = 1'b0;
    end
    always @(posedge clk) begin
        float_q <= ~ad_w;
        ad_q <= ad_w;
        rdy_q <= !rdy_line;
    end
    task automatic access(input logic sty, input logic mux, input logic csn, input logic wr,
                          input logic [7:0] loc, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk);
        #1;
        ctrl.host_style_select = sty;
        ctrl.bus_sharing_select = mux;
        ctrl.cs_n = csn;
        ctrl.ale = 1'b1;
        addr_v = mux ? ~loc : loc;
        host_ad = loc;
        host_en = mux;
        repeat (3) @(posedge clk);
        #1;
        ctrl.ale = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        host_en = wr;
        host_ad = wd;
        ctrl.combined_fetch_pin = !sty && wr;
        ctrl.combined_store_pin = !wr;
        for (int n = 0; n < 12; n++) begin
            @(posedge clk);
            #1;
            if (rdy_q) break;
        end
        rd = ad_q;
        got_ready = rdy_q;
        ctrl = 6'h3e;
        host_en = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : access
endmodule : host_bus_model

/* testbench/tb_host_port.sv */
// Self-checking bench for the host port driven through the host bus model.
`timescale 1ns/1ps
module tb_host_port;
    logic clk;
    logic rst;
    logic [7:0] irq_events;
    logic [3:0] core_status;
    host_port_pkg::host_ctrl_t ctrl;
    host_port_pkg::host_bus_t bus;
    logic [7:0] ad_out;
    logic ad_oe, ready_out, ready_oe, irq_out, irq_oe, sleep;
    logic [1:0] synth_rate, host_clk_rate;
    logic [7:0] monitor_select, line_port_config, rd;
    int miscompares, comparisons, cycles;
    wire irq_line = irq_oe ? irq_out : 1'b1;
    host_bus_model u_host (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe), .ready_out(ready_out),
        .ready_oe(ready_oe), .ctrl(ctrl), .bus(bus));
    host_port u_dut (.clk(clk), .rst(rst), .ctrl_pins(ctrl), .bus_pins(bus),
        .ad_out(ad_out), .ad_oe(ad_oe), .ready_out(ready_out), .ready_oe(ready_oe),
        .irq_out(irq_out), .irq_oe(irq_oe), .irq_events(irq_events),
        .core_status(core_status), .sleep(sleep), .synth_rate(synth_rate),
        .host_clk_rate(host_clk_rate), .monitor_select(monitor_select),
        .line_port_config(line_port_config));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic sty, input logic mux, input logic [7:0] loc, input logic [7:0] d);
        u_host.access(sty, mux, 1'b0, 1'b1, loc, d, rd);
        check({7'h00, u_host.got_ready}, 8'h01);
    endtask : wr
    task automatic rdc(input logic sty, input logic mux, input logic [7:0] loc, input logic [7:0] e);
        u_host.access(sty, mux, 1'b0, 1'b0, loc, 8'h00, rd);
        check({7'h00, u_host.got_ready}, 8'h01);
        check(rd, e);
    endtask : rdc
    task automatic do_reset();
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic pulse(input logic [7:0] ev);
        @(posedge clk);
        #1;
        irq_events = ev;
        @(posedge clk);
        #1;
        irq_events = 8'h00;
        repeat (3) @(posedge clk);
        #1;
    endtask : pulse
    task automatic t_reset_vals();
        check({7'h00, sleep}, 8'h01);
        check({4'h0, synth_rate, host_clk_rate}, 8'h00);
        rdc(1'b1, 1'b1, 8'h00, 8'ha1);
        rdc(1'b1, 1'b1, 8'h22, 8'h00);
        $display("reset values done");
    endtask : t_reset_vals
    task automatic t_select_style();
        wr(1'b1, 1'b1, 8'h06, 8'ha5);
        rdc(1'b1, 1'b1, 8'h06, 8'ha5);
        check(line_port_config, 8'ha5);
        wr(1'b1, 1'b0, 8'h01, 8'h3f);
        rdc(1'b1, 1'b0, 8'h01, 8'h3f);
        check({6'h00, host_clk_rate}, 8'h03);
        check(monitor_select, 8'h3f);
        $display("select style done");
    endtask : t_select_style
    task automatic t_strobe_style();
        wr(1'b0, 1'b0, 8'h22, 8'h83);
        rdc(1'b0, 1'b0, 8'h22, 8'h83);
        check({6'h00, synth_rate}, 8'h03);
        wr(1'b0, 1'b1, 8'h06, 8'h5a);
        rdc(1'b0, 1'b1, 8'h06, 8'h5a);
        $display("strobe style done");
    endtask : t_strobe_style
    task automatic t_refused();
        u_host.access(1'b1, 1'b1, 1'b1, 1'b1, 8'h06, 8'hff, rd);
        check({7'h00, u_host.got_ready}, 8'h00);
        check(line_port_config, 8'h5a);
        wr(1'b0, 1'b0, 8'h7e, 8'h11);
        rdc(1'b0, 1'b0, 8'h7e, 8'h00);
        wr(1'b0, 1'b0, 8'h00, 8'h5e);
        rdc(1'b1, 1'b1, 8'h00, 8'hae);
        check({7'h00, sleep}, 8'h00);
        $display("refused access done");
    endtask : t_refused
    task automatic t_mid_reset();
        do_reset();
        check({7'h00, sleep}, 8'h01);
        check({4'h0, synth_rate, host_clk_rate}, 8'h00);
        rdc(1'b1, 1'b1, 8'h06, 8'h00);
        $display("mid reset done");
    endtask : t_mid_reset
    task automatic t_irq();
        wr(1'b1, 1'b1, 8'h41, 8'hfe);
        pulse(8'h02);
        check({7'h00, irq_line}, 8'h01);
        pulse(8'h01);
        check({7'h00, irq_line}, 8'h00);
        rdc(1'b1, 1'b1, 8'h40, 8'h03);
        wr(1'b1, 1'b1, 8'h40, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        check({7'h00, irq_line}, 8'h01);
        rdc(1'b1, 1'b1, 8'h40, 8'h02);
        $display("interrupt done");
    endtask : t_irq
    initial begin
        rst = 1'b1;
        irq_events = 8'h00;
        core_status = 4'ha;
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        do_reset();
        t_reset_vals();
        t_select_style();
        t_strobe_style();
        t_refused();
        t_mid_reset();
        t_irq();
        end_sim();
    end
endmodule : tb_host_port
